// File: fmc_pkg.sv
// Shared constants, types and helpers for the frame memory resume block
package fmc_pkg;
    localparam int FMC_PTR_W = 9;
    localparam int FMC_PIX_W = 18;
    // Array size defaults; any access window must fit inside them
    localparam int FMC_COLS = 256;
    localparam int FMC_PAGES = 256;
    // Cycles taken by the zero sweep after hardware reset, one word per cycle
    localparam int FMC_CLEAR_CYCLES = FMC_COLS * FMC_PAGES;
    localparam logic [7:0] FMC_CMD_WR_RESUME = 8'h3C;
    localparam logic [7:0] FMC_CMD_RD_RESUME = 8'h3E;
    localparam logic [2:0] FMC_FMT_16 = 3'h5;
    localparam logic [2:0] FMC_FMT_18 = 3'h6;
    localparam logic [2:0] FMC_FMT_RESET = 3'h6;
    localparam logic [FMC_PIX_W-1:0] FMC_DUMMY_WORD = 18'h00000;
    localparam logic [FMC_PIX_W-1:0] FMC_DATA_RESET = 18'h00000;
    localparam logic [FMC_PTR_W-1:0] FMC_PTR_RESET = 9'h000;

    typedef enum logic [1:0] {FMC_IDLE, FMC_WRITE, FMC_READ} fmc_mode_type;

    typedef struct packed {
        logic [FMC_PTR_W-1:0] first_column;
        logic [FMC_PTR_W-1:0] last_column;
        logic [FMC_PTR_W-1:0] first_page;
        logic [FMC_PTR_W-1:0] last_page;
    } fmc_window_type;

    typedef struct packed {
        logic data_command_select;
        logic read_strobe_n;
        logic write_strobe_n;
        logic [FMC_PIX_W-1:0] data;
    } fmc_bus_type;

    // Host word to stored 18-bit pixel; 16-bit words widen red and blue
    function automatic logic [FMC_PIX_W-1:0] fmc_pixel_in(input logic [2:0] fmt,
                                                          input logic [FMC_PIX_W-1:0] d);
        if (fmt == FMC_FMT_16)
            fmc_pixel_in = {d[15:11], d[15], d[10:5], d[4:0], d[4]};
        else
            fmc_pixel_in = d;
    endfunction
endpackage

// File: fmc_walker.sv
// Column and page pointer that walks the access window
`timescale 1ns/1ps
module fmc_walker
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Control
    input wire logic load_i,
    input wire logic step_i,
    input wire logic wrap_i,
    input wire logic address_order_bit_i,
    input wire fmc_pkg::fmc_window_type window_i,
    // Position
    output logic [fmc_pkg::FMC_PTR_W-1:0] column_o,
    output logic [fmc_pkg::FMC_PTR_W-1:0] page_o,
    output logic ended_o
);
    import fmc_pkg::*;

    logic [FMC_PTR_W-1:0] column;
    logic [FMC_PTR_W-1:0] page;
    logic ended;
    logic [FMC_PTR_W-1:0] next_column;
    logic [FMC_PTR_W-1:0] next_page;
    logic next_ended;
    logic last_col;
    logic last_pg;

    assign last_col = (column == window_i.last_column);
    assign last_pg = (page == window_i.last_page);

    // Next pointer position for one stored or returned pixel
    always_comb
    begin
        next_column = column;
        next_page = page;
        next_ended = ended;
        if (load_i)
        begin
            next_column = window_i.first_column;
            next_page = window_i.first_page;
            next_ended = 1'b0;
        end
        else if (step_i && !ended)
        begin
            if (last_col && last_pg)
            begin
                if (wrap_i)
                begin
                    next_column = window_i.first_column;
                    next_page = window_i.first_page;
                end
                else
                    next_ended = 1'b1;
            end
            else if (!address_order_bit_i)
            begin
                if (!last_col)
                    next_column = column + 9'h001;
                else
                begin
                    next_column = window_i.first_column;
                    next_page = page + 9'h001;
                end
            end
            else
            begin
                if (!last_pg)
                    next_page = page + 9'h001;
                else
                begin
                    next_page = window_i.first_page;
                    next_column = column + 9'h001;
                end
            end
        end
    end

    // Pointer registers
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            column <= FMC_PTR_RESET;
            page <= FMC_PTR_RESET;
            ended <= 1'b0;
        end
        else
        begin
            column <= next_column;
            page <= next_page;
            ended <= next_ended;
        end
    end

    assign column_o = column;
    assign page_o = page;
    assign ended_o = ended;
endmodule

// File: fmc_top.sv
// Frame memory with write-resume and read-resume command handling
// Notes on behaviour
// - Code 3C taken on write strobe rise
// - Pixel words follow, each latched on rise
// - Write resumes after last written pixel
// - Order 0: column first, then page
// - Order 1: page first, then column
// - Transfer ends at window end (reads, or writes with wrap off) or command
// - Wrap off: surplus pixels discarded
// - Wrap on: surplus writes restart at window origin
// - Code 3E starts a read resume
// - First read is dummy, then pixels
// - Read resumes after last read pixel
// - Resume accepted in every power state
// - Memory zeroed on hardware reset only
// - Pixel word decoded by pixel format
`timescale 1ns/1ps
module fmc_top
#(
    parameter int COLS = fmc_pkg::FMC_COLS,
    parameter int PAGES = fmc_pkg::FMC_PAGES,
    parameter int CLEAR_CYCLES = fmc_pkg::FMC_CLEAR_CYCLES
)
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Host parallel bus
    input wire fmc_pkg::fmc_bus_type bus_i,
    output logic [fmc_pkg::FMC_PIX_W-1:0] data_o,
    output logic data_oe_o,
    // Window and mode settings
    input wire fmc_pkg::fmc_window_type window_i,
    input wire logic address_order_bit_i,
    input wire logic overflow_wrap_mode_i,
    input wire logic [2:0] pixel_format_i,
    // Start command pulses from the command decoder
    input wire logic write_start_i,
    input wire logic read_start_i,
    // Status
    output logic write_active_o,
    output logic read_active_o,
    output logic clear_busy_o
);
    import fmc_pkg::*;

    localparam int DEPTH = COLS * PAGES;
    localparam int ADDR_W = $clog2(DEPTH);

    logic [FMC_PIX_W-1:0] mem [DEPTH];
    logic [FMC_PIX_W-1:0] rd_word;

    fmc_mode_type mode;
    fmc_mode_type next_mode;
    logic dummy_pending;
    logic next_dummy_pending;
    logic [FMC_PIX_W-1:0] data;
    logic [FMC_PIX_W-1:0] next_data;
    logic wr_q;
    logic rd_q;
    logic clear_busy;
    logic next_clear_busy;
    logic [ADDR_W-1:0] clear_addr;
    logic [ADDR_W-1:0] next_clear_addr;

    logic wr_rise;
    logic rd_fall;
    logic cmd_take;
    logic pix_take;
    logic read_take;
    logic read_step;
    logic [FMC_PTR_W-1:0] wr_col;
    logic [FMC_PTR_W-1:0] wr_page;
    logic wr_end;
    logic [FMC_PTR_W-1:0] rd_col;
    logic [FMC_PTR_W-1:0] rd_page;
    logic rd_end;
    logic [ADDR_W-1:0] wr_addr;
    logic [ADDR_W-1:0] rd_addr;

    // Linear memory index of a column and page position
    function automatic logic [ADDR_W-1:0] mem_index(input logic [FMC_PTR_W-1:0] col,
                                                    input logic [FMC_PTR_W-1:0] pg);
        mem_index = ADDR_W'(ADDR_W'(pg) * ADDR_W'(COLS) + ADDR_W'(col));
    endfunction

    // Strobe edges; inputs are synchronous to the system clock
    assign wr_rise = bus_i.write_strobe_n && !wr_q;
    assign rd_fall = !bus_i.read_strobe_n && rd_q;
    // No power state gates command capture
    assign cmd_take = wr_rise && !bus_i.data_command_select && bus_i.read_strobe_n;
    assign pix_take = wr_rise && bus_i.data_command_select && bus_i.read_strobe_n
                      && (mode == FMC_WRITE) && !wr_end && !clear_busy;
    assign read_take = rd_fall && bus_i.data_command_select && bus_i.write_strobe_n
                       && (mode == FMC_READ);
    assign read_step = read_take && !dummy_pending && !rd_end;

    // Write position survives any other command
    fmc_walker u_write_walker
    (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .load_i(write_start_i),
        .step_i(pix_take),
        .wrap_i(overflow_wrap_mode_i),
        .address_order_bit_i(address_order_bit_i),
        .window_i(window_i),
        .column_o(wr_col),
        .page_o(wr_page),
        .ended_o(wr_end)
    );

    // Read position survives any other command; reads never wrap
    fmc_walker u_read_walker
    (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .load_i(read_start_i),
        .step_i(read_step),
        .wrap_i(1'b0),
        .address_order_bit_i(address_order_bit_i),
        .window_i(window_i),
        .column_o(rd_col),
        .page_o(rd_page),
        .ended_o(rd_end)
    );

    assign wr_addr = mem_index(wr_col, wr_page);
    assign rd_addr = mem_index(rd_col, rd_page);

    // Command mode, dummy cycle and read data
    always_comb
    begin
        next_mode = mode;
        next_dummy_pending = dummy_pending;
        next_data = data;
        if (cmd_take)
        begin
            next_dummy_pending = 1'b0;
            if (bus_i.data[7:0] == FMC_CMD_WR_RESUME)
                next_mode = FMC_WRITE;
            else if (bus_i.data[7:0] == FMC_CMD_RD_RESUME)
            begin
                next_mode = FMC_READ;
                next_dummy_pending = 1'b1;
            end
            else
                next_mode = FMC_IDLE;
        end
        else if (read_take)
        begin
            if (dummy_pending)
            begin
                next_data = FMC_DUMMY_WORD;
                next_dummy_pending = 1'b0;
            end
            else if (rd_end)
                next_data = FMC_DATA_RESET;
            else
                next_data = rd_word;
        end
        if (write_start_i || read_start_i)
            next_mode = FMC_IDLE;
    end

    // Zero sweep of the whole memory after hardware reset
    always_comb
    begin
        next_clear_busy = clear_busy;
        next_clear_addr = clear_addr;
        if (clear_busy)
        begin
            if (clear_addr == ADDR_W'(CLEAR_CYCLES - 1))
                next_clear_busy = 1'b0;
            else
                next_clear_addr = clear_addr + ADDR_W'(1);
        end
    end

    // Control registers
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            mode <= FMC_IDLE;
            dummy_pending <= 1'b0;
            data <= FMC_DATA_RESET;
            wr_q <= 1'b1;
            rd_q <= 1'b1;
            clear_busy <= 1'b1;
            clear_addr <= '0;
        end
        else
        begin
            mode <= next_mode;
            dummy_pending <= next_dummy_pending;
            data <= next_data;
            wr_q <= bus_i.write_strobe_n;
            rd_q <= bus_i.read_strobe_n;
            clear_busy <= next_clear_busy;
            clear_addr <= next_clear_addr;
        end
    end

    // Frame memory: sweep writes zeros, then host pixels land in order
    always_ff @(posedge clk_sys_i)
    begin
        if (clear_busy)
            mem[clear_addr] <= FMC_DATA_RESET;
        else if (pix_take)
            mem[wr_addr] <= fmc_pixel_in(pixel_format_i, bus_i.data);
        rd_word <= mem[rd_addr];
    end

    assign data_o = data;
    // Drive the bus only while the host holds read strobe low in a read
    assign data_oe_o = (mode == FMC_READ) && bus_i.data_command_select
                       && !bus_i.read_strobe_n && bus_i.write_strobe_n;
    assign write_active_o = (mode == FMC_WRITE);
    assign read_active_o = (mode == FMC_READ);
    assign clear_busy_o = clear_busy;
endmodule

// File: fmc_host.sv
// Host processor model on the parallel command and data bus
`timescale 1ns/1ps
module fmc_host
(
    // Clock
    input wire logic clk_sys_i,
    // Bus towards the device
    output fmc_pkg::fmc_bus_type bus_o,
    input wire logic [fmc_pkg::FMC_PIX_W-1:0] data_i
);
    import fmc_pkg::*;
    // Idle bus with both strobes high
    initial bus_o = {3'h7, 18'h3FFFF};
    // One write strobe cycle; data goes to its inverse a cycle after release
    task automatic put(input logic dcs, input logic [FMC_PIX_W-1:0] d);
        @(posedge clk_sys_i) #1;
        bus_o = {dcs, 2'h2, d};
        @(posedge clk_sys_i) #1;
        bus_o.write_strobe_n = 1'b1;
        @(posedge clk_sys_i) #1;
        bus_o.data = ~d;
    endtask
    // One read strobe cycle; word taken a cycle after the fall
    task automatic get(output logic [FMC_PIX_W-1:0] q);
        @(posedge clk_sys_i) #1;
        bus_o = {3'h5, bus_o.data};
        @(posedge clk_sys_i) #1;
        bus_o.read_strobe_n = 1'b1;
        q = data_i;
        repeat (2) @(posedge clk_sys_i);
    endtask
endmodule

// File: fmc_top_sva.sv
// Port checker for the frame memory resume block
`timescale 1ns/1ps
module fmc_top_sva
#(
    parameter int CLEAR_CYCLES = fmc_pkg::FMC_CLEAR_CYCLES
)
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Host bus
    input wire fmc_pkg::fmc_bus_type bus_i,
    input wire logic [fmc_pkg::FMC_PIX_W-1:0] data_o,
    input wire logic data_oe_o,
    // Start pulses
    input wire logic write_start_i,
    input wire logic read_start_i,
    // Status
    input wire logic write_active_o,
    input wire logic read_active_o,
    input wire logic clear_busy_o
);
    import fmc_pkg::*;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);
    logic wr_q;
    logic cmd_rise;
    logic first_rd;
    logic next_first_rd;
    int busy_cnt;
    int next_busy_cnt;
    // Command strobe rise as the device takes it
    assign cmd_rise = bus_i.write_strobe_n && !wr_q && !bus_i.data_command_select
        && bus_i.read_strobe_n;
    // Dummy slot after a read resume and length of the zero sweep
    always_comb
    begin
        next_busy_cnt = clear_busy_o ? busy_cnt + 1 : busy_cnt;
        next_first_rd = first_rd && bus_i.read_strobe_n && !write_start_i && !read_start_i;
        if (cmd_rise)
            next_first_rd = bus_i.data[7:0] == FMC_CMD_RD_RESUME;
    end
    // Helper registers
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            wr_q <= 1'b1;
            first_rd <= 1'b0;
            busy_cnt <= 0;
        end
        else
        begin
            wr_q <= bus_i.write_strobe_n;
            first_rd <= next_first_rd;
            busy_cnt <= next_busy_cnt;
        end
    end
    sequence s_cmd(logic [7:0] code);
        cmd_rise && bus_i.data[7:0] == code;
    endsequence
    sequence s_rd_fall(logic armed);
        armed && !bus_i.read_strobe_n && $past(bus_i.read_strobe_n) && bus_i.data_command_select;
    endsequence
    AST_CMD_WR: assert property (s_cmd(FMC_CMD_WR_RESUME) |=> write_active_o && !read_active_o)
        else $error("write resume not entered");
    AST_CMD_RD: assert property (s_cmd(FMC_CMD_RD_RESUME) |=> read_active_o && !write_active_o)
        else $error("read resume not entered");
    AST_CMD_END: assert property (cmd_rise && bus_i.data[7:0] != FMC_CMD_WR_RESUME
        && bus_i.data[7:0] != FMC_CMD_RD_RESUME |=> !write_active_o && !read_active_o)
        else $error("other command did not end transfer");
    AST_START: assert property (write_start_i || read_start_i |=> !write_active_o && !read_active_o)
        else $error("start pulse did not end transfer");
    AST_OE: assert property (data_oe_o |-> bus_i.data_command_select && !bus_i.read_strobe_n)
        else $error("data driven outside a read strobe");
    AST_OE_ON: assert property (read_active_o && bus_i.data_command_select
        && !bus_i.read_strobe_n && bus_i.write_strobe_n |-> data_oe_o)
        else $error("data not driven during a read strobe");
    AST_RD_STABLE: assert property ($changed(data_o) |-> !$past(bus_i.read_strobe_n))
        else $error("read word changed without a read");
    AST_DUMMY: assert property (s_rd_fall(first_rd) |=> data_o == FMC_DUMMY_WORD)
        else $error("first read word not the dummy");
    AST_CLEAR_LEN: assert property ($fell(clear_busy_o) |-> busy_cnt >= CLEAR_CYCLES - 1
        && busy_cnt <= CLEAR_CYCLES + 1)
        else $error("zero sweep length wrong");
endmodule
bind fmc_top fmc_top_sva #(.CLEAR_CYCLES(CLEAR_CYCLES)) fmc_top_sva_inst (.clk_sys_i, .sys_rst_i,
    .bus_i, .data_o, .data_oe_o, .write_start_i, .read_start_i, .write_active_o,
    .read_active_o, .clear_busy_o);

// File: fmc_top_tb.sv
// Self-checking bench for the frame memory resume block
`timescale 1ns/1ps
module fmc_top_tb;
    import fmc_pkg::*;
    typedef struct packed {
        logic ord_w;
        logic ord_r;
        logic wrap;
        logic [2:0] fmt;
        logic [1:0] extra;
    } fmc_row_type;
    // Window 3 columns by 2 pages; orders, wrap, format, surplus pixels
    fmc_row_type rows [4] = '{'{1'h0, 1'h0, 1'h0, 3'h6, 2'h2}, '{1'h1, 1'h1, 1'h1, 3'h6, 2'h2},
        '{1'h0, 1'h1, 1'h0, 3'h5, 2'h0}, '{1'h1, 1'h0, 1'h1, 3'h6, 2'h3}};
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    fmc_bus_type bus;
    logic [FMC_PIX_W-1:0] data_o;
    logic data_oe_o;
    logic order = 1'b0;
    logic wrap = 1'b0;
    logic [2:0] fmt = 3'h6;
    logic wstart = 1'b0;
    logic rstart = 1'b0;
    logic clear_busy_o;
    logic wr_act;
    logic rd_act;
    int failures = 0;
    int n_tests = 0;
    logic [FMC_PIX_W-1:0] q;
    fmc_top #(.COLS(8), .PAGES(4), .CLEAR_CYCLES(32)) fmc_top_inst (.clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i), .bus_i(bus), .data_o(data_o), .data_oe_o(data_oe_o),
        .window_i({9'h002, 9'h004, 9'h001, 9'h002}), .address_order_bit_i(order),
        .overflow_wrap_mode_i(wrap), .pixel_format_i(fmt), .write_start_i(wstart),
        .read_start_i(rstart), .write_active_o(wr_act), .read_active_o(rd_act),
        .clear_busy_o(clear_busy_o));
    fmc_host fmc_host_inst (.clk_sys_i(clk_sys_i), .bus_o(bus), .data_i(data_o));
    // Clock
    always #5 clk_sys_i = ~clk_sys_i;
    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Start pulse standing for the start commands
    task automatic start(input logic rd);
        @(posedge clk_sys_i) #1;
        {wstart, rstart} = {!rd, rd};
        @(posedge clk_sys_i) #1;
        {wstart, rstart} = 2'h0;
    endtask
    task automatic wait_clear();
        for (int n = 0; n < 100 && clear_busy_o !== 1'b0; n++)
            @(posedge clk_sys_i) #1;
        check("sweep", {17'h0, clear_busy_o}, 18'h0);
    endtask
    function automatic logic [17:0] pix(input int r, input int i, input logic [2:0] f);
        logic [17:0] d;
        d = 18'h2C35A + 18'h01111 * 18'(r * 8 + i);
        return f == 3'h5 ? {d[15:11], d[15], d[10:5], d[4:0], d[4]} : d;
    endfunction
    // Write index of the k-th read position
    function automatic int idx(input logic ow, input logic orr, input int k);
        int c;
        int p;
        c = orr ? k / 2 : k % 3;
        p = orr ? k % 2 : k / 3;
        return ow ? c * 2 + p : p * 3 + c;
    endfunction
    task automatic run_row(input int r);
        int j;
        {order, wrap, fmt} = {rows[r].ord_w, rows[r].wrap, rows[r].fmt};
        start(1'b0);
        for (int i = 0; i < 6 + rows[r].extra; i++)
        begin
            if (i == 3)
                fmc_host_inst.put(1'b0, {10'h000, FMC_CMD_RD_RESUME});
            if (i == 0 || i == 3)
            begin
                fmc_host_inst.put(1'b0, {10'h000, FMC_CMD_WR_RESUME});
                check("write mode", {17'h0, wr_act}, 18'h1);
            end
            fmc_host_inst.put(1'b1, pix(r, i, 3'h0));
        end
        order = rows[r].ord_r;
        start(1'b1);
        for (int k = 0; k < 7; k++)
        begin
            if (k == 3)
            begin
                fmc_host_inst.put(1'b0, 18'h00029);
                check("mode ended", {16'h0, wr_act, rd_act}, 18'h0);
            end
            if (k == 0 || k == 3)
            begin
                fmc_host_inst.put(1'b0, {10'h000, FMC_CMD_RD_RESUME});
                check("read mode", {17'h0, rd_act}, 18'h1);
                fmc_host_inst.get(q);
                check("dummy", q, FMC_DUMMY_WORD);
            end
            j = idx(rows[r].ord_w, rows[r].ord_r, k);
            j = (rows[r].wrap && j < rows[r].extra) ? j + 6 : j;
            fmc_host_inst.get(q);
            check("pixel", q, k < 6 ? pix(r, j, rows[r].fmt) : 18'h0);
        end
    endtask
    // Main sequence: rows, then a second hardware reset
    initial
    begin
        repeat (6) @(posedge clk_sys_i);
        check("busy", {17'h0, clear_busy_o}, 18'h1);
        #1 sys_rst_i = 1'b0;
        wait_clear();
        foreach (rows[r])
            run_row(r);
        @(posedge clk_sys_i) #1;
        sys_rst_i = 1'b1;
        #1 check("oe", {17'h0, data_oe_o}, 18'h0);
        check("busy again", {17'h0, clear_busy_o}, 18'h1);
        repeat (2) @(posedge clk_sys_i);
        #1 sys_rst_i = 1'b0;
        wait_clear();
        start(1'b1);
        fmc_host_inst.put(1'b0, {10'h000, FMC_CMD_RD_RESUME});
        // Bus drive is looked at while the read strobe is low
        fork
            fmc_host_inst.get(q);
            begin
                @(posedge clk_sys_i) #2;
                check("drive", {17'h0, data_oe_o}, 18'h1);
            end
        join
        check("zeroed", q, 18'h0);
        repeat (6)
        begin
            fmc_host_inst.get(q);
            check("zeroed", q, 18'h0);
        end
        stop_test();
    end
    // Watchdog
    initial
    begin
        #100000;
        failures++;
        stop_test();
    end
endmodule
